// >>> hw/xaui_regs_pkg.sv
// register map, field layout and link framing constants for the coding-path register bank
package xaui_regs_pkg;
    localparam int LANES = 4;

    // register addresses, management device space
    localparam logic [15:0] TX_PATH_BYPASS_ADDR = 16'h8019;
    localparam logic [15:0] RX_COMP_STATUS_ADDR = 16'h801a;
    localparam logic [15:0] RX_INSERT_CNT_ADDR = 16'h801b;
    localparam logic [15:0] RX_DELETE_CNT_ADDR = 16'h801c;
    localparam logic [15:0] LANE_INACT_ADDR = 16'h801d;
    localparam logic [15:0] RX_PATH_BYPASS_ADDR = 16'h801e;

    // transmit bypass control fields
    localparam int TX_IPG_BIT = 15;
    localparam int TX_COMP_BIT = 11;
    localparam int TX_ENC_LSB = 4;
    localparam logic [15:0] TX_MASK = 16'h88f0;

    // receive compensation status fields
    localparam int RX_OVF_LSB = 6;
    localparam int RX_UNF_LSB = 2;
    localparam int ANY_OVF_BIT = 1;
    localparam int ANY_UNF_BIT = 0;

    // receive bypass control fields
    localparam int RX_COMP_BIT = 15;
    localparam int RX_IPG_BIT = 14;
    localparam int RX_DEC_LSB = 8;
    localparam int RX_SEQ_BIT = 7;
    localparam int RX_ALIGN_BIT = 3;
    localparam logic [15:0] RX_MASK = 16'hcf88;

    // values after reset, and the counter saturation value
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'hfffd;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // lane inactivity threshold, in lane cycles
    localparam logic [11:0] DOWN_CYCLES = 12'hfff;

    // management frame layout
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] HDR_BITS = 5'he;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] ST_CODE = 2'h0;
    localparam logic [1:0] OP_ADDR = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RINC = 2'h2;
    localparam logic [4:0] DEV_PHY_XS = 5'h4;
    localparam logic [4:0] DEV_DTE_XS = 5'h5;

    typedef enum logic [5:0] {
        S_HUNT = 6'b000001,
        S_HDR = 6'b000010,
        S_RDTA = 6'b000100,
        S_RDATA = 6'b001000,
        S_WRTA = 6'b010000,
        S_WDATA = 6'b100000
    } mgmt_state_t;
endpackage

// >>> hw/lane_fifo.sv
// parameterised fifo with a registered output stage
`timescale 1ns/1ps
module lane_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;

    wire push = inValid && inReady;
    wire load = (count != '0) && (!outValid || outReady);

    // ready drops honestly when storage is full, so a stalled sink backs up the source
    assign inReady = count != DEPTH[AW:0];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (load) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            outData <= '0;
        end else if (load) begin
            outValid <= 1'b1;
            outData <= mem[rdPtr];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule // lane_fifo

// >>> hw/xaui_pcs_bypass_status_regs.sv
// coding-path bypass control and status registers behind the management link
`timescale 1ns/1ps
module xaui_pcs_bypass_status_regs #(
    parameter int LANE_W = 10,
    parameter int FIFO_DEPTH = 8,
    parameter logic [4:0] PORT_ADDR = 5'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [xaui_regs_pkg::LANES-1:0] compOverflow,
    input wire logic [xaui_regs_pkg::LANES-1:0] compUnderflow,
    input wire logic idleInsert,
    input wire logic idleDelete,
    input wire logic rxLaneValid,
    output logic rxLaneReady,
    input wire logic [xaui_regs_pkg::LANES*LANE_W-1:0] rxLaneData,
    output logic xgmiiValid,
    input wire logic xgmiiReady,
    output logic [xaui_regs_pkg::LANES*LANE_W-1:0] xgmiiData,
    output logic txIpgBypass,
    output logic txCompBypass,
    output logic [xaui_regs_pkg::LANES-1:0] txEncBypass,
    output logic rxCompBypass,
    output logic rxIpgCheckBypass,
    output logic [xaui_regs_pkg::LANES-1:0] rxDecBypass,
    output logic rxSeqIsIpg,
    output logic rxAlignBypass
);
    import xaui_regs_pkg::*;

    // link synchronisers; stage 2 of mdcSync is only the edge-detect history
    logic [2:0] mdcSync;
    logic [1:0] mdioSync;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdcSync <= 3'h0;
            mdioSync <= 2'h0;
        end else begin
            mdcSync <= {mdcSync[1:0], mdc};
            mdioSync <= {mdioSync[0], mdioIn};
        end
    end

    wire mdcRise = mdcSync[1] && !mdcSync[2];
    wire mdioBit = mdioSync[1];

    // frame decoder
    mgmt_state_t state;
    logic [5:0] preCnt;
    logic [4:0] bitCnt;
    logic [13:0] hdr;
    logic [1:0] opReg;
    logic [15:0] wShift;
    logic [15:0] rdShift;
    logic [15:0] addrReg;

    wire [13:0] nextHdr = {hdr[12:0], mdioBit};
    wire [15:0] wrData = {wShift[14:0], mdioBit};
    wire devMatch = (nextHdr[4:0] == DEV_PHY_XS) || (nextHdr[4:0] == DEV_DTE_XS);
    wire hdrMatch = (nextHdr[13:12] == ST_CODE) && (nextHdr[9:5] == PORT_ADDR) && devMatch;
    wire hdrLast = bitCnt == HDR_BITS - 5'h1;
    wire dataLast = bitCnt == DATA_BITS - 5'h1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= S_HUNT;
            preCnt <= 6'h00;
            bitCnt <= 5'h00;
            hdr <= 14'h0000;
            opReg <= 2'h0;
            wShift <= 16'h0000;
        end else if (mdcRise) begin
            case (state)
                S_HUNT: begin
                    bitCnt <= 5'h01;
                    hdr <= 14'h0000;
                    if (mdioBit) begin
                        preCnt <= (preCnt == PREAMBLE_BITS) ? preCnt : preCnt + 6'h01;
                    end else begin
                        preCnt <= 6'h00;
                        if (preCnt == PREAMBLE_BITS) begin
                            state <= S_HDR;
                        end
                    end
                end
                S_HDR: begin
                    hdr <= nextHdr;
                    bitCnt <= hdrLast ? 5'h00 : bitCnt + 5'h01;
                    if (hdrLast) begin
                        opReg <= nextHdr[11:10];
                        // a frame for another port or device is skipped whole
                        if (!hdrMatch) begin
                            state <= S_HUNT;
                        end else if (nextHdr[11]) begin
                            state <= S_RDTA;
                        end else begin
                            state <= S_WRTA;
                        end
                    end
                end
                S_RDTA: begin
                    bitCnt <= (bitCnt == 5'h01) ? 5'h00 : bitCnt + 5'h01;
                    if (bitCnt == 5'h01) begin
                        state <= S_RDATA;
                    end
                end
                S_RDATA: begin
                    bitCnt <= dataLast ? 5'h00 : bitCnt + 5'h01;
                    if (dataLast) begin
                        state <= S_HUNT;
                    end
                end
                S_WRTA: begin
                    bitCnt <= (bitCnt == 5'h01) ? 5'h00 : bitCnt + 5'h01;
                    if (bitCnt == 5'h01) begin
                        state <= S_WDATA;
                    end
                end
                S_WDATA: begin
                    wShift <= wrData;
                    bitCnt <= dataLast ? 5'h00 : bitCnt + 5'h01;
                    if (dataLast) begin
                        state <= S_HUNT;
                    end
                end
                default: state <= S_HUNT;
            endcase
        end
    end

    wire rdPulse = mdcRise && (state == S_RDTA) && (bitCnt == 5'h00);
    wire wrDone = mdcRise && (state == S_WDATA) && dataLast;
    wire wrPulse = wrDone && (opReg == OP_WRITE);
    wire addrPulse = wrDone && (opReg == OP_ADDR);
    wire rincPulse = mdcRise && (state == S_RDATA) && dataLast && (opReg == OP_RINC);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addrReg <= 16'h0000;
        end else if (addrPulse) begin
            addrReg <= wrData;
        end else if (rincPulse) begin
            addrReg <= addrReg + 16'h0001;
        end
    end

    // address decode
    wire selTx = addrReg == TX_PATH_BYPASS_ADDR;
    wire selStatus = addrReg == RX_COMP_STATUS_ADDR;
    wire selIns = addrReg == RX_INSERT_CNT_ADDR;
    wire selDel = addrReg == RX_DELETE_CNT_ADDR;
    wire selDown = addrReg == LANE_INACT_ADDR;
    wire selRx = addrReg == RX_PATH_BYPASS_ADDR;

    // control registers
    logic [15:0] txCtrl;
    logic [15:0] rxCtrl;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txCtrl <= CTRL_RESET;
            rxCtrl <= CTRL_RESET;
        end else if (wrPulse) begin
            if (selTx) txCtrl <= wrData & TX_MASK;
            if (selRx) rxCtrl <= wrData & RX_MASK;
        end
    end

    assign txIpgBypass = txCtrl[TX_IPG_BIT];
    assign txCompBypass = txCtrl[TX_COMP_BIT];
    assign txEncBypass = txCtrl[TX_ENC_LSB +: LANES];
    assign rxCompBypass = rxCtrl[RX_COMP_BIT];
    assign rxIpgCheckBypass = rxCtrl[RX_IPG_BIT];
    assign rxDecBypass = rxCtrl[RX_DEC_LSB +: LANES];
    assign rxSeqIsIpg = rxCtrl[RX_SEQ_BIT];
    assign rxAlignBypass = rxCtrl[RX_ALIGN_BIT];

    // compensation flags: sticky until read, a new event wins over the clear
    logic [LANES-1:0] ovfFlag;
    logic [LANES-1:0] unfFlag;
    wire statusClr = rdPulse && selStatus;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovfFlag <= '0;
            unfFlag <= '0;
        end else begin
            ovfFlag <= (statusClr ? '0 : ovfFlag) | compOverflow;
            unfFlag <= (statusClr ? '0 : unfFlag) | compUnderflow;
        end
    end

    wire [15:0] statusWord = {6'h00, ovfFlag, unfFlag, |ovfFlag, |unfFlag};

    // idle counters; in bypass the datapath must not insert or delete, so stray strobes are dropped
    logic [15:0] insCnt;
    logic [15:0] delCnt;
    wire insEv = idleInsert && !rxCompBypass;
    wire delEv = idleDelete && !rxCompBypass;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            insCnt <= COUNT_RESET;
            delCnt <= COUNT_RESET;
        end else begin
            if (rdPulse && selIns) insCnt <= {15'h0000, insEv};
            else if (insEv && insCnt != COUNT_MAX) insCnt <= insCnt + 16'h0001;
            if (rdPulse && selDel) delCnt <= {15'h0000, delEv};
            else if (delEv && delCnt != COUNT_MAX) delCnt <= delCnt + 16'h0001;
        end
    end

    // receive lane stream through the fifo, watched for inactivity at its input
    wire laneTake = rxLaneValid && rxLaneReady;
    logic [LANES-1:0] downFlag;
    logic [LANES-1:0] downNow;
    wire downClr = rdPulse && selDown;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] lastSym;
            logic [11:0] idleCnt;
            logic downSeen;
            assign downFlag[g] = downSeen;
            wire toggled = laneTake && (rxLaneData[g*LANE_W +: LANE_W] != lastSym);
            assign downNow[g] = idleCnt == DOWN_CYCLES;

            // a stalled or silent lane counts as not toggling
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    lastSym <= '0;
                    idleCnt <= 12'h000;
                    downSeen <= 1'b0;
                end else begin
                    if (laneTake) lastSym <= rxLaneData[g*LANE_W +: LANE_W];
                    if (toggled) idleCnt <= 12'h000;
                    else if (!downNow[g]) idleCnt <= idleCnt + 12'h001;
                    downSeen <= (downClr ? 1'b0 : downSeen) | downNow[g];
                end
            end
        end
    endgenerate

    lane_fifo #(
        .WIDTH(LANES*LANE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(rxLaneValid),
        .inReady(rxLaneReady),
        .inData(rxLaneData),
        .outValid(xgmiiValid),
        .outReady(xgmiiReady),
        .outData(xgmiiData)
    );

    // read mux; unmapped and undefined bits read zero
    wire [15:0] readValue =
        selTx ? txCtrl :
        selStatus ? statusWord :
        selIns ? insCnt :
        selDel ? delCnt :
        selDown ? {12'h000, downFlag} :
        selRx ? rxCtrl : 16'h0000;

    // read drive: z on the first turnaround bit, 0 on the second, then msb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
            rdShift <= 16'h0000;
        end else if (mdcRise) begin
            if (rdPulse) begin
                rdShift <= readValue;
                mdioOe <= 1'b1;
                mdioOut <= 1'b0;
            end else if ((state == S_RDTA) || (state == S_RDATA && !dataLast)) begin
                mdioOut <= rdShift[15];
                rdShift <= {rdShift[14:0], 1'b0};
            end else begin
                mdioOe <= 1'b0;
                mdioOut <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_tx_ipg_write: assert property (wrPulse && selTx |=> txIpgBypass == $past(wrData[15]))
        else $error("gap bypass did not follow write");
    a_tx_comp_write: assert property (wrPulse && selTx |=> txCompBypass == $past(wrData[11]))
        else $error("tx comp bypass did not follow write");
    a_tx_enc_lanes: assert property (wrPulse && selTx |=> txEncBypass == $past(wrData[7:4]))
        else $error("encoder bypass lanes wrong");
    a_ovf_flag_set: assert property (compOverflow[0] |=> statusWord[6] && statusWord[1])
        else $error("lane 0 overflow not flagged");
    a_unf_flag_set: assert property (compUnderflow[3] |=> statusWord[5] && statusWord[0])
        else $error("lane 3 underflow not flagged");
    a_any_summary: assert property (statusClr && !(|compOverflow) |=> !statusWord[1])
        else $error("overflow summary survived clear");
    a_ins_count: assert property (insEv && !(rdPulse && selIns) && insCnt < COUNT_MAX
        |=> insCnt == $past(insCnt) + 16'h0001)
        else $error("insert counter did not step");
    a_del_clear: assert property (rdPulse && selDel && !delEv |=> delCnt == 16'h0000)
        else $error("delete counter not cleared by read");
    a_down_quiet: assert property ($rose(downFlag[3]) |-> $past(downNow[3]))
        else $error("data down raised early");
    a_comp_bypass: assert property (rxCompBypass && !(rdPulse && (selIns || selDel))
        |=> $stable(insCnt) && $stable(delCnt))
        else $error("counters moved in bypass");
    a_rx_dec_lanes: assert property (wrPulse && selRx |=> rxDecBypass == $past(wrData[11:8]))
        else $error("decoder bypass lanes wrong");
    a_reserved_zero: assert property (wrPulse |=> (txCtrl & ~TX_MASK) == 16'h0000
        && (rxCtrl & ~RX_MASK) == 16'h0000)
        else $error("reserved bit stored");

    c_read_frame: cover property (rdPulse ##[1:300] !mdioOe);
    c_tx_write: cover property (wrPulse && selTx);
    c_lane_down: cover property (downNow[3] && !downFlag[3]);
    c_fifo_full: cover property (rxLaneValid && !rxLaneReady);
endmodule // xaui_pcs_bypass_status_regs

// >>> dv/mgmt_station.sv
// management station model driving whole frames on the management link
`timescale 1ns/1ps
module mgmt_station (
    output logic mdc,
    output logic stOut,
    output logic stOe,
    input wire logic mdioWire
);
    import xaui_regs_pkg::*;
    initial begin
        mdc = 1'b0;
        stOut = 1'b1;
        stOe = 1'b0;
    end
    // mdc stands low between frames; each frame carries its own full preamble
    task automatic frame(input logic [1:0] op, input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        bits = {32'hffffffff, ST_CODE, op, 5'h00, DEV_PHY_XS, 2'h2, wdata};
        rdata = 16'h0000;
        // small offset keeps the link phase unrelated to the core clock
        #3;
        for (int i = 0; i < 64; i++) begin
            stOe = !(op[1] && i >= 46);
            stOut = bits[63-i];
            #62.5 mdc = 1'b1;
            if (op[1] && i >= 48) begin
                rdata = {rdata[14:0], mdioWire};
            end
            #62.5 mdc = 1'b0;
        end
        stOe = 1'b0;
    endtask
endmodule // mgmt_station

// >>> dv/xaui_pcs_bypass_status_regs_tb.sv
// self-checking bench for the coding-path register bank and its lane fifo
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module xaui_pcs_bypass_status_regs_tb;
    import xaui_regs_pkg::*;
    typedef struct {string n; logic [39:0] e; logic [39:0] g;} note_t;
    logic clk, rst_n, mdc, stOut, stOe, mdioOut, mdioOe, mdioWire, acc, hold, run;
    logic [3:0] compOverflow, compUnderflow, txEncBypass, rxDecBypass;
    logic idleInsert, idleDelete, rxLaneValid, rxLaneReady, xgmiiValid, xgmiiReady;
    logic [39:0] rxLaneData, xgmiiData;
    logic txIpgBypass, txCompBypass, rxCompBypass, rxIpgCheckBypass, rxSeqIsIpg, rxAlignBypass;
    logic [31:0] seed = 32'd99;
    logic [31:0] r;
    // the lane stream redraws r every cycle, so the scenario keeps its own draw
    logic [31:0] rs;
    logic [15:0] rv, ni, nd;
    logic [15:0] sweep [0:6] = '{16'h0, 16'h0, 16'hfffd, 16'hfffd, 16'h8, 16'h0, 16'h0};
    logic [15:0] pat [0:2];
    int n_errors, checks, k;
    note_t regQ[$];
    logic [39:0] sQ[$];

    // released line is pulled up
    assign mdioWire = mdioOe ? mdioOut : (stOe ? stOut : 1'b1);

    mgmt_station u_mgmt_station (.mdc(mdc), .stOut(stOut), .stOe(stOe), .mdioWire(mdioWire));
    xaui_pcs_bypass_status_regs u_xaui_pcs_bypass_status_regs (
        .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .compOverflow(compOverflow), .compUnderflow(compUnderflow),
        .idleInsert(idleInsert), .idleDelete(idleDelete), .rxLaneValid(rxLaneValid),
        .rxLaneReady(rxLaneReady), .rxLaneData(rxLaneData), .xgmiiValid(xgmiiValid),
        .xgmiiReady(xgmiiReady), .xgmiiData(xgmiiData), .txIpgBypass(txIpgBypass),
        .txCompBypass(txCompBypass), .txEncBypass(txEncBypass), .rxCompBypass(rxCompBypass),
        .rxIpgCheckBypass(rxIpgCheckBypass), .rxDecBypass(rxDecBypass),
        .rxSeqIsIpg(rxSeqIsIpg), .rxAlignBypass(rxAlignBypass)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic note(input string n, input logic [39:0] e, input logic [39:0] g);
        regQ.push_back('{n, e, g});
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        u_mgmt_station.frame(OP_ADDR, a, d);
        u_mgmt_station.frame(2'h3, 16'h0, d);
        note(n, {24'h0, e}, {24'h0, d});
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        logic [15:0] d;
        u_mgmt_station.frame(OP_ADDR, a, d);
        u_mgmt_station.frame(OP_WRITE, v, d);
        repeat (8) @(negedge clk);
    endtask

    task automatic pulses(input logic [15:0] a, input logic [15:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            idleInsert = i < a;
            idleDelete = i < b;
        end
        @(negedge clk);
        idleInsert = 1'b0;
        idleDelete = 1'b0;
    endtask

    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // lane 3 never changes so it must report down; lanes 0..2 are redrawn at random on every word
    initial begin
        rxLaneValid = 1'b0;
        rxLaneData = 40'h0;
        xgmiiReady = 1'b0;
        forever begin
            @(negedge clk);
            r = rnd();
            xgmiiReady = !hold && r[1:0] != 2'b00;
            if (!rxLaneValid || acc) begin
                rxLaneValid = run && r[3:2] != 2'b00;
                rxLaneData = {10'h155, r[31:2]};
            end
        end
    end

    always @(posedge clk) begin
        note_t t;
        logic [39:0] ex;
        if (xgmiiValid === 1'b1 && xgmiiReady) begin
            ex = (sQ.size() > 0) ? sQ.pop_front() : 'x;
            `CHK("xgmiiData", ex, xgmiiData)
        end
        acc = rxLaneValid && rxLaneReady === 1'b1;
        if (acc) begin
            sQ.push_back(rxLaneData);
        end
        while (regQ.size() > 0) begin
            t = regQ.pop_front();
            `CHK(t.n, t.e, t.g)
        end
    end

    initial begin
        rst_n = 1'b0;
        compOverflow = 4'h0;
        compUnderflow = 4'h0;
        idleInsert = 1'b0;
        idleDelete = 1'b0;
        hold = 1'b0;
        run = 1'b0;
        n_errors = 0;
        checks = 0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        run = 1'b1;
        // reset values across the whole map with read-increment, except lane 3 already reported down, one unmapped place at the end
        u_mgmt_station.frame(OP_ADDR, TX_PATH_BYPASS_ADDR, rv);
        foreach (sweep[i]) begin
            u_mgmt_station.frame(OP_RINC, 16'h0, rv);
            note("sweep", {24'h0, sweep[i]}, {24'h0, rv});
        end
        rs = rnd();
        ni = {13'h0, rs[10:8]} + 16'h1;
        nd = {13'h0, rs[13:11]} + 16'h1;
        @(negedge clk);
        compOverflow = rs[3:0];
        compUnderflow = rs[7:4];
        @(negedge clk);
        compOverflow = 4'h0;
        compUnderflow = 4'h0;
        pulses(ni, nd);
        rd(RX_COMP_STATUS_ADDR, {6'h0, rs[3:0], rs[7:4], |rs[3:0], |rs[7:4]}, "compStatus");
        rd(RX_COMP_STATUS_ADDR, 16'h0, "compStatusCleared");
        rd(RX_INSERT_CNT_ADDR, ni, "insertCount");
        rd(RX_DELETE_CNT_ADDR, nd, "deleteCount");
        rd(RX_INSERT_CNT_ADDR, 16'h0, "insertCleared");
        pat[0] = 16'hffff;
        pat[1] = 16'h8a50;
        pat[2] = rs[31:16];
        foreach (pat[i]) begin
            wr(TX_PATH_BYPASS_ADDR, pat[i]);
            wr(RX_PATH_BYPASS_ADDR, ~pat[i]);
            rd(TX_PATH_BYPASS_ADDR, pat[i] & 16'h88f0, "txControl");
            rd(RX_PATH_BYPASS_ADDR, ~pat[i] & 16'hcf88, "rxControl");
            rv = ~pat[i];
            note("txOut", {34'h0, pat[i][15], pat[i][11], pat[i][7:4]},
                {34'h0, txIpgBypass, txCompBypass, txEncBypass});
            note("rxOut", {32'h0, rv[15], rv[14], rv[11:8], rv[7], rv[3]}, {32'h0, rxCompBypass,
                rxIpgCheckBypass, rxDecBypass, rxSeqIsIpg, rxAlignBypass});
        end
        // strobes while compensation is bypassed must not reach the counters
        wr(RX_PATH_BYPASS_ADDR, 16'h8000);
        pulses(16'h5, 16'h4);
        wr(RX_PATH_BYPASS_ADDR, 16'h0000);
        pulses(16'h2, 16'h1);
        rd(RX_INSERT_CNT_ADDR, 16'h2, "insertAfterBypass");
        rd(RX_DELETE_CNT_ADDR, 16'h1, "deleteAfterBypass");
        rd(LANE_INACT_ADDR, 16'h8, "laneDown");
        hold = 1'b1;
        for (k = 0; k < 50 && rxLaneReady !== 1'b0; k++) @(negedge clk);
        note("fifoFull", 40'h1, {39'h0, sQ.size() >= 8 && rxLaneReady === 1'b0});
        hold = 1'b0;
        run = 1'b0;
        for (k = 0; k < 300 && (sQ.size() > 0 || rxLaneValid); k++) @(negedge clk);
        if (k == 300) begin
            n_errors++;
        end
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule // xaui_pcs_bypass_status_regs_tb
